// file: hw/pwm4_top.sv
// Purpose: Four channel 10-bit pulse width modulator with double buffered period and duty.
// Assumes: Byte register port with read data one cycle after the read strobe.
// Notes:   Pin latch set-up is left to software; outputs are internal channel levels.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "pwm4_cfg.svh"

module pwm4_top
  import pwm4_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire pwm4_pkg::pwm4_byte_t reg_addr,
  input  wire pwm4_pkg::pwm4_byte_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output pwm4_pkg::pwm4_byte_t      reg_rdata,
  output pwm4_pkg::pwm4_chan_t      pwm_out
);
  import pwm4_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam pwm4_byte_t DUTY_LO_OFS [4] = '{`PWM4_OFS_DUTY0_LO, `PWM4_OFS_DUTY1_LO,
                                             `PWM4_OFS_DUTY2_LO, `PWM4_OFS_DUTY3_LO};
  localparam pwm4_byte_t DUTY_HI_OFS [4] = '{`PWM4_OFS_DUTY0_HI, `PWM4_OFS_DUTY1_HI,
                                             `PWM4_OFS_DUTY2_HI, `PWM4_OFS_DUTY3_HI};

  logic       run_q;
  logic       load_q;
  logic       flag_q;
  pwm4_chan_t inv_q;
  pwm4_byte_t prescale_q;
  pwm4_val_t  period_buf_q;
  pwm4_val_t  period_work_q;
  pwm4_val_t  cnt_q;
  pwm4_val_t  cnt_d;
  logic       xfer_q;
  pwm4_byte_t rdata_q;
  pwm4_byte_t rdata_d;
  pwm4_val_t  duty_buf_q  [4];
  pwm4_val_t  cmp_work_q  [4];
  pwm4_chan_t level_q;
  pwm4_chan_t out_q;

  logic       ctl_wr;
  logic       clear_req;
  logic       tick;
  logic       underflow;
  logic       xfer;

  // ==========================================================================
  // Write decode
  // ==========================================================================
  assign ctl_wr    = reg_wr && (reg_addr == `PWM4_OFS_CONTROL);
  assign clear_req = ctl_wr && reg_wdata[`PWM4_CTL_CLEAR];

  // ==========================================================================
  // Control and prescale registers
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      inv_q <= 4'h0;
    end else if (ctl_wr) begin
      run_q <= reg_wdata[`PWM4_CTL_RUN];
      inv_q <= reg_wdata[`PWM4_CTL_INV_HI:`PWM4_CTL_INV_LO];
    end
  end

  // Load request: a software write wins over the hardware clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      load_q <= 1'b0;
    end else if (ctl_wr) begin
      load_q <= reg_wdata[`PWM4_CTL_LOAD];
    end else if (xfer_q) begin
      load_q <= 1'b0;
    end
  end

  // Underflow flag: the hardware set wins over a software clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
    end else if (underflow) begin
      flag_q <= 1'b1;
    end else if (ctl_wr) begin
      flag_q <= reg_wdata[`PWM4_CTL_FLAG];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prescale_q <= `PWM4_RST_PRESCALE;
    end else if (reg_wr && (reg_addr == `PWM4_OFS_PRESCALE)) begin
      prescale_q <= reg_wdata;
    end
  end

  // ==========================================================================
  // Period holding buffer
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      period_buf_q <= `PWM4_RST_VAL;
    end else if (reg_wr && (reg_addr == `PWM4_OFS_PERIOD_LO)) begin
      period_buf_q[7:0] <= reg_wdata;
    end else if (reg_wr && (reg_addr == `PWM4_OFS_PERIOD_HI)) begin
      period_buf_q[9:8] <= reg_wdata[`PWM4_HI_BITS-1:0];
    end
  end

  // ==========================================================================
  // Counter clock
  // ==========================================================================
  pwm4_prescale u_prescale (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (run_q),
    .restart (clear_req),
    .div     (prescale_q),
    .tick    (tick)
  );

  // ==========================================================================
  // Shared down counter
  // ==========================================================================
  assign underflow = tick && (cnt_q == `PWM4_CNT_CLEAR_VAL);
  assign xfer      = underflow && load_q;

  always_comb begin
    cnt_d = cnt_q;
    if (clear_req) begin
      cnt_d = `PWM4_CNT_CLEAR_VAL;
    end else if (underflow) begin
      cnt_d = load_q ? period_buf_q : period_work_q;
    end else if (tick) begin
      cnt_d = cnt_q - 10'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= `PWM4_RST_VAL;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      period_work_q <= `PWM4_RST_VAL;
    end else if (xfer) begin
      period_work_q <= period_buf_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= xfer;
    end
  end

  // ==========================================================================
  // Channels
  // ==========================================================================
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan

    // Holding buffer of this channel's compare value.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        duty_buf_q[ch] <= `PWM4_RST_VAL;
      end else if (reg_wr && (reg_addr == DUTY_LO_OFS[ch])) begin
        duty_buf_q[ch][7:0] <= reg_wdata;
      end else if (reg_wr && (reg_addr == DUTY_HI_OFS[ch])) begin
        duty_buf_q[ch][9:8] <= reg_wdata[`PWM4_HI_BITS-1:0];
      end
    end

    // Working compare value, loaded only at a period boundary.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        cmp_work_q[ch] <= `PWM4_RST_VAL;
      end else if (xfer) begin
        cmp_work_q[ch] <= duty_buf_q[ch];
      end
    end

    // Comparator level; frozen while the counter is halted.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        level_q[ch] <= `PWM4_RST_LEVEL;
      end else if (run_q) begin
        if (cmp_work_q[ch] == `PWM4_CMP_ALL_ONES) begin
          level_q[ch] <= 1'b0;
        end else begin
          level_q[ch] <= (cnt_q >= cmp_work_q[ch]);
        end
      end
    end

    // Output stage with polarity control.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        out_q[ch] <= `PWM4_RST_LEVEL;
      end else begin
        out_q[ch] <= level_q[ch] ^ inv_q[ch];
      end
    end
  end

  assign pwm_out = out_q;

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    rdata_d = `PWM4_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `PWM4_OFS_CONTROL: begin
          rdata_d = {run_q, load_q, flag_q, 1'b0, inv_q};
        end
        `PWM4_OFS_PERIOD_LO: begin
          rdata_d = period_buf_q[7:0];
        end
        `PWM4_OFS_PERIOD_HI: begin
          rdata_d = {6'h00, period_buf_q[9:8]};
        end
        `PWM4_OFS_PRESCALE: begin
          rdata_d = prescale_q;
        end
        default: begin
          rdata_d = `PWM4_RST_BYTE;
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (reg_addr == DUTY_LO_OFS[i]) begin
          rdata_d = duty_buf_q[i][7:0];
        end
        if (reg_addr == DUTY_HI_OFS[i]) begin
          rdata_d = {6'h00, duty_buf_q[i][9:8]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `PWM4_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// file: hw/pwm4_cfg.svh
// Purpose: Register offsets, field positions and reset values of the four channel PWM.
// Assumes: Byte wide register port, offsets are byte addresses on that port.
// Notes:   Definitions only.
`ifndef PWM4_CFG_SVH
`define PWM4_CFG_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define PWM4_OFS_PERIOD_HI   8'hd1
`define PWM4_OFS_DUTY0_HI    8'hd2
`define PWM4_OFS_DUTY1_HI    8'hd3
`define PWM4_OFS_PRESCALE    8'hd4
`define PWM4_OFS_DUTY2_HI    8'hd5
`define PWM4_OFS_DUTY3_HI    8'hd6
`define PWM4_OFS_PERIOD_LO   8'hd9
`define PWM4_OFS_DUTY0_LO    8'hda
`define PWM4_OFS_DUTY1_LO    8'hdb
`define PWM4_OFS_CONTROL     8'hdc
`define PWM4_OFS_DUTY2_LO    8'hdd
`define PWM4_OFS_DUTY3_LO    8'hde

// ==========================================================================
// Main control register fields
// ==========================================================================
`define PWM4_CTL_RUN         7
`define PWM4_CTL_LOAD        6
`define PWM4_CTL_FLAG        5
`define PWM4_CTL_CLEAR       4
`define PWM4_CTL_INV_HI      3
`define PWM4_CTL_INV_LO      0

// ==========================================================================
// Value layout, reset values and special compare codes
// ==========================================================================
`define PWM4_HI_BITS         2
`define PWM4_RST_BYTE        8'h00
`define PWM4_RST_VAL         10'h000
`define PWM4_RST_PRESCALE    8'h00
`define PWM4_CNT_CLEAR_VAL   10'h000
`define PWM4_CMP_ALL_ONES    10'h3ff
`define PWM4_RST_LEVEL       1'b1

`endif

// file: hw/pwm4_pkg.sv
// Purpose: Shared types of the four channel PWM.
// Assumes: Constants come from pwm4_cfg.svh.
// Notes:   Types only.
package pwm4_pkg;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef logic [7:0] pwm4_byte_t;
  typedef logic [9:0] pwm4_val_t;
  typedef logic [3:0] pwm4_chan_t;

endpackage

// file: hw/pwm4_prescale.sv
// Purpose: Counter clock enable for the PWM down counter.
// Assumes: Divider field value N gives one tick every N+1 system clocks.
// Notes:   Ticks only while running; a restart realigns the divider.
`timescale 1ns/10ps
`include "pwm4_cfg.svh"

module pwm4_prescale
  import pwm4_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              run,
  input  wire logic              restart,
  input  wire pwm4_pkg::pwm4_byte_t div,
  output logic                   tick
);
  import pwm4_pkg::*;

  pwm4_byte_t div_cnt_q;

  // ==========================================================================
  // Divider
  // ==========================================================================
  // A tick is issued when the divider reaches the programmed ratio.
  assign tick = run && !restart && (div_cnt_q >= div);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= `PWM4_RST_PRESCALE;
    end else if (!run || restart || tick) begin
      div_cnt_q <= `PWM4_RST_PRESCALE;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

endmodule

// file: test/pwm4_top_asserts.sv
// Purpose: Port assertions of the PWM.
// Assumes: Read data stand one cycle.
// Notes:   Bound below.
`timescale 1ns/10ps
module pwm4_top_asserts
  import pwm4_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 nrst,
  input wire pwm4_pkg::pwm4_byte_t reg_addr,
  input wire pwm4_pkg::pwm4_byte_t reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire pwm4_pkg::pwm4_byte_t reg_rdata,
  input wire pwm4_pkg::pwm4_chan_t pwm_out
);
  // ==========
  // Checks.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("rdata not idle");
  a_reset_high: assert property (!$past(nrst) |-> pwm_out == 4'hf)
    else $error("outputs not high");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_hi_mask: assert property (reg_rd && reg_addr inside {8'hd1, 8'hd2, 8'hd3, 8'hd5, 8'hd6}
    |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits");
  a_clear_reads0: assert property (reg_rd && reg_addr == 8'hdc |=> !reg_rdata[4])
    else $error("clear bit read");
  a_period_echo: assert property (reg_wr && reg_addr == 8'hd9 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'hd9
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("period echo");
  a_ctl_echo: assert property (reg_wr && reg_addr == 8'hdc ##1 !reg_wr ##1 reg_rd && reg_addr == 8'hdc
    |=> {reg_rdata[7], reg_rdata[3:0]} == {$past(reg_wdata[7], 3), $past(reg_wdata[3:0], 3)})
    else $error("control echo");
  a_halt_hold: assert property (reg_wr && reg_addr == 8'hdc && !reg_wdata[7] ##1 !reg_wr [*6]
    |-> pwm_out == $past(pwm_out, 3)) else $error("halt moved");
  c_start: cover property (reg_wr && reg_addr == 8'hdc && reg_wdata == 8'hd0);
  c_loaded: cover property (reg_rd && reg_addr == 8'hdc ##1 !reg_rdata[6]);
  c_toggle: cover property ($changed(pwm_out));
endmodule
bind pwm4_top pwm4_top_asserts u_chk(.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_out);

// file: test/pwm4_load.sv
// Purpose: Load on the outputs, counts high time and ch0 rise spacing.
// Assumes: Port latches set.
// Notes:   High-time counts restart on clr.
`timescale 1ns/10ps
module pwm4_load
  import pwm4_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire pwm4_pkg::pwm4_chan_t pwm_out,
  input  wire logic                 clr,
  output logic [15:0]               hi [4],
  output logic [15:0]               gap
);
  // ==========
  // Counters.
  logic [15:0] run_q = 16'h0000;
  logic        prev_q = 1'b1;
  // Pins follow the channels since the latches are set.
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      hi[i] <= clr ? 16'h0000 : hi[i] + {15'h0000, pwm_out[i]};
    end
    prev_q <= pwm_out[0];
    if (pwm_out[0] && !prev_q) begin
      gap <= run_q;
      run_q <= 16'h0001;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule

// file: test/test_pwm4_top.sv
// Purpose: Bench of the PWM.
// Assumes: Read data one cycle after strobe.
// Notes:   Small periods, then two full ten-bit periods.
`timescale 1ns/10ps
module test_pwm4_top;
  import pwm4_pkg::*;
  // ==========
  // Signals.
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  pwm4_byte_t  reg_addr = 8'h00;
  pwm4_byte_t  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  pwm4_byte_t  reg_rdata;
  pwm4_chan_t  pwm_out;
  logic        clr = 1'b0;
  logic [15:0] hi [4];
  logic [15:0] gap;
  pwm4_byte_t  d;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  pwm4_top u_dut(.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_out);
  pwm4_load u_load(.ref_clk, .pwm_out, .clr, .hi, .gap);
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(pwm4_byte_t a, pwm4_byte_t v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(pwm4_byte_t a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic set10(pwm4_byte_t a, logic [9:0] v);
    wr(a, v[7:0]);
    wr(a - 8'h08, {6'h00, v[9:8]});
  endtask
  task automatic wait_load();
    for (int i = 0; i < 40; i++) begin
      rd(8'hdc);
      if (d[6] === 1'b0) begin
        return;
      end
    end
    chk("load wait", 16'h0000, 16'h0001);
    final_report();
  endtask
  task automatic meas(int n, logic [15:0] e0, e1, e2, e3, eg);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    chk("ch0", e0, hi[0]);
    chk("ch1", e1, hi[1]);
    chk("ch2", e2, hi[2]);
    chk("ch3", e3, hi[3]);
    chk("gap", eg, gap);
  endtask
  task automatic t_regs();
    pwm4_byte_t a [6] = '{8'hd9, 8'hda, 8'hdb, 8'hdd, 8'hde, 8'hdc};
    chk("reset out", 16'h000f, {12'h000, pwm_out});
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset lo", 16'h0000, {8'h00, d});
      rd(a[i] - 8'h08);
      chk("reset hi", 16'h0000, {8'h00, d});
      if (i < 5) begin
        wr(a[i] - 8'h08, 8'hff);
        rd(a[i] - 8'h08);
        chk("high reg", 16'h0003, {8'h00, d});
        wr(a[i], 8'ha5);
        rd(a[i]);
        chk("low reg", 16'h00a5, {8'h00, d});
      end
    end
    rd(8'h00);
    chk("unmapped", 16'h0000, {8'h00, d});
  endtask
  task automatic t_wave();
    set10(8'hd9, 10'h003);
    set10(8'hda, 10'h002);
    set10(8'hdb, 10'h000);
    set10(8'hdd, 10'h3ff);
    set10(8'hde, 10'h005);
    chk("idle out", 16'h000f, {12'h000, pwm_out});
    wr(8'hdc, 8'hd0);
    wait_load();
    chk("flag", 16'h0001, {15'h0000, d[5]});
    repeat (4) @(posedge ref_clk);
    meas(16, 16'h0008, 16'h0010, 16'h0000, 16'h0000, 16'h0004);
  endtask
  task automatic t_buffer();
    set10(8'hd9, 10'h007);
    set10(8'hda, 10'h004);
    set10(8'hde, 10'h009);
    meas(16, 16'h0008, 16'h0010, 16'h0000, 16'h0000, 16'h0004);
    wr(8'hdc, 8'hc0);
    wait_load();
    repeat (4) @(posedge ref_clk);
    meas(32, 16'h0010, 16'h0020, 16'h0000, 16'h0000, 16'h0008);
    wr(8'hd4, 8'h01);
    meas(48, 16'h0018, 16'h0030, 16'h0000, 16'h0000, 16'h0010);
  endtask
  task automatic t_halt();
    pwm4_chan_t v;
    wr(8'hdc, 8'h00);
    repeat (4) @(posedge ref_clk);
    #1;
    v = pwm_out;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("halt", {12'h000, 3'b001, v[0]}, {12'h000, pwm_out});
    wr(8'hdc, 8'h0f);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("invert", {12'h000, 3'b110, ~v[0]}, {12'h000, pwm_out});
  endtask
  // Full ten-bit period: all-ones compare must stay low even where the counter reaches it.
  task automatic t_full();
    set10(8'hd9, 10'h3ff);
    set10(8'hda, 10'h200);
    set10(8'hdb, 10'h000);
    set10(8'hdd, 10'h3ff);
    set10(8'hde, 10'h3fe);
    wr(8'hd4, 8'h00);
    wr(8'hdc, 8'hd0);
    wait_load();
    repeat (4) @(posedge ref_clk);
    meas(2048, 16'h0400, 16'h0800, 16'h0000, 16'h0004, 16'h0400);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_wave();
    t_buffer();
    t_halt();
    t_full();
    final_report();
  end
endmodule
